//--- rtl/ogl_gap_loop.sv
// gap classifier, loopback control, retiming fifo and test pattern source
`default_nettype none

// synchronous fifo with width and depth parameters
module ogl_fifo #(
  parameter int W     = 36,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         reset_n,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("fifo depth must be a power of two");
    end
  end

  logic [W-1:0] mem_r [DEPTH];
  logic [AW:0]  wp_r;
  logic [AW:0]  wp_nxt;
  logic [AW:0]  rp_r;
  logic [AW:0]  rp_nxt;
  logic         push;
  logic         pop;

  // full and empty from pointer wrap bits
  always_comb begin
    in_ready  = !((wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]));
    out_valid = (wp_r != rp_r);
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    wp_nxt    = push ? wp_r + 1'b1 : wp_r;
    rp_nxt    = pop ? rp_r + 1'b1 : rp_r;
    out_data  = mem_r[rp_r[AW-1:0]];
  end

  // pointer registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end

  // storage, written only on push
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_r[wp_r[AW-1:0]] <= in_data;
    end
  end
endmodule

// top: runs on the recovered link clock
module ogl_gap_loop
  import ogl_pkg::*;
#(
  parameter int  PAY_DW      = FRAME_PAY_DW,
  parameter int  ALIGN_EVERY = ALIGN_PERIOD,
  parameter int  DEPTH       = FIFO_DEPTH,
  parameter bit  HAS_FE_ANA  = 1'b1,
  parameter bit  HAS_NE_ANA  = 1'b1
) (
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          reset_n,
  // squelch detector and unit interval strobe
  input  wire logic          oob_activity,
  input  wire logic          oob_ui_tick,
  input  wire ogl_gap_lim_t  wake_lim,
  input  wire ogl_gap_lim_t  init_lim,
  input  wire logic          accept_may,
  output logic               wake_gap_ok,
  output logic               wake_gap_bad,
  output logic               init_gap_ok,
  output logic               init_gap_bad,
  output logic               init_seq_seen,
  // loopback control
  input  wire logic          bist_req,
  input  wire ogl_bist_t     bist_kind,
  input  wire logic          ne_lb_req,
  input  wire logic          far_quiet,
  output logic               fe_retimed_on,
  output logic               fe_analog_on,
  output logic               ne_analog_on,
  // received dwords from the data_recovery_circuit
  input  wire logic          rx_valid,
  output logic               rx_ready,
  input  wire ogl_dword_t    rx_word,
  // pattern generator control
  input  wire ogl_gen_mode_t gen_mode,
  input  wire logic [31:0]   gen_pattern,
  // toward link scrambler and serializer
  input  wire logic          tx_ready,
  output logic               tx_valid,
  output ogl_dword_t         tx_word,
  output logic               tx_bypass_scr
);
  initial begin
    if (PAY_DW < 1 || PAY_DW > 65535 || ALIGN_EVERY < 4) begin
      $error("frame length or align period out of range");
    end
  end

  // Notes on behaviour
  // - gaps in the optional wake range are accepted when accept_may is set
  // - gaps in the mandatory wake range are always accepted
  // - gaps in forbidden wake ranges are never accepted
  // - optional init/reset range gaps accepted when accept_may is set
  // - mandatory init/reset range gaps are always accepted
  // - forbidden init/reset range gaps are flagged invalid
  // - retimed loopback built in; both analog loopbacks optional
  // - far-end loopbacks entered only on a self-test activate request
  // - retimed loopback held until an init/reset sequence arrives
  // - far-end analog loopback held until an init/reset sequence arrives
  // - looped data comes from the recovered dword stream
  // - align pairs inserted on return path to absorb rate difference
  // - no descrambling in the return path, so scrambling is untouched
  // - returned dwords equal received ones, disparity may differ
  // - near-end analog only while the far end is silent
  // - raw mode repeats one dword with no framing
  // - framed mode sends start, header, payload, check, end in order
  // - align pairs keep coming during framed patterns
  // - payload repeated up to the longest frame length
  // - payload pre-scrambled so the pattern appears on the wire

  localparam int AC_W = $clog2(ALIGN_EVERY + 1);

  // next scrambler state and word over one dword
  function automatic logic [47:0] scr_step(input logic [15:0] s);
    logic [15:0] st;
    logic [31:0] w;
    st = s;
    w  = '0;
    for (int i = 0; i < 32; i++) begin
      w[i] = st[15];
      st   = {st[14:0], 1'b0} ^ (st[15] ? SCR_TAPS : 16'h0000);
    end
    return {st, w};
  endfunction

  // frame check over one dword
  function automatic logic [31:0] crc_step(input logic [31:0] c,
                                           input logic [31:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 31; i >= 0; i--) begin
      r = {r[30:0], 1'b0} ^ ((r[31] ^ d[i]) ? CRC_POLY : 32'h00000000);
    end
    return r;
  endfunction

  // gap class check against the four limits
  function automatic logic gap_valid(input logic [15:0] n,
                                     input ogl_gap_lim_t l,
                                     input logic opt);
    logic mand;
    logic may;
    mand = (n >= l.shall_lo) && (n <= l.shall_hi);
    may  = (n >= l.may_lo) && (n <= l.may_hi);
    return mand || (may && opt);
  endfunction

  // squelch input: three flops, a change counts once two and three agree
  logic [2:0] act_sync_r;
  logic       act_r;
  logic       act_nxt;
  logic       in_gap_r;
  logic       in_gap_nxt;
  logic [15:0] gap_cnt_r;
  logic [15:0] gap_cnt_nxt;
  logic       gap_end;
  logic       wk_ok;
  logic       in_ok;
  logic [1:0] init_run_r;
  logic [1:0] init_run_nxt;
  logic [4:0] gap_out_nxt;

  // gap measurement and classification
  always_comb begin
    act_nxt     = (act_sync_r[1] == act_sync_r[2]) ? act_sync_r[2] : act_r;
    gap_end     = in_gap_r && act_nxt && !act_r;
    in_gap_nxt  = in_gap_r;
    gap_cnt_nxt = gap_cnt_r;
    if (act_r && !act_nxt) begin
      in_gap_nxt  = 1'b1; // last edge of a burst
      gap_cnt_nxt = '0;
    end else if (gap_end) begin
      in_gap_nxt  = 1'b0; // first edge of the next burst
    end else if (in_gap_r && oob_ui_tick && gap_cnt_r != 16'hffff) begin
      gap_cnt_nxt = gap_cnt_r + 16'h0001;
    end
    wk_ok = gap_valid(gap_cnt_r, wake_lim, accept_may);
    in_ok = gap_valid(gap_cnt_r, init_lim, accept_may);
    init_run_nxt = init_run_r;
    gap_out_nxt  = '0;
    if (gap_end) begin
      gap_out_nxt[3:0] = {wk_ok, !wk_ok, in_ok, !in_ok};
      if (!in_ok) begin
        init_run_nxt = '0;
      end else if (init_run_r == 2'(INIT_GAPS - 1)) begin
        init_run_nxt   = '0;
        gap_out_nxt[4] = 1'b1; // init/reset sequence complete
      end else begin
        init_run_nxt = init_run_r + 2'h1;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      act_sync_r <= '0;
      act_r      <= 1'b0;
      in_gap_r   <= 1'b0;
      gap_cnt_r  <= '0;
      init_run_r <= '0;
      {wake_gap_ok, wake_gap_bad, init_gap_ok, init_gap_bad} <= '0;
      init_seq_seen <= 1'b0;
    end else begin
      act_sync_r <= {act_sync_r[1:0], oob_activity};
      act_r      <= act_nxt;
      in_gap_r   <= in_gap_nxt;
      gap_cnt_r  <= gap_cnt_nxt;
      init_run_r <= init_run_nxt;
      {wake_gap_ok, wake_gap_bad, init_gap_ok, init_gap_bad} <=
        gap_out_nxt[3:0];
      init_seq_seen <= gap_out_nxt[4];
    end
  end

  a_wake_forbidden: assert property (@(posedge mclk) disable iff (!reset_n)
    gap_end && (gap_cnt_r < wake_lim.may_lo || gap_cnt_r > wake_lim.may_hi)
    |=> !wake_gap_ok && wake_gap_bad)
    else $error("forbidden wake gap accepted");
  a_wake_mandatory: assert property (@(posedge mclk) disable iff (!reset_n)
    gap_end && gap_cnt_r >= wake_lim.shall_lo && gap_cnt_r <= wake_lim.shall_hi
    |=> wake_gap_ok)
    else $error("mandatory wake gap missed");
  a_init_forbidden: assert property (@(posedge mclk) disable iff (!reset_n)
    gap_end && (gap_cnt_r < init_lim.may_lo || gap_cnt_r > init_lim.may_hi)
    |=> init_gap_bad && !init_gap_ok)
    else $error("forbidden init gap accepted");
  a_init_mandatory: assert property (@(posedge mclk) disable iff (!reset_n)
    gap_end && gap_cnt_r >= init_lim.shall_lo && gap_cnt_r <= init_lim.shall_hi
    |=> init_gap_ok)
    else $error("mandatory init gap missed");

  // loopback mode machine
  typedef enum logic [3:0] {
    LB_IDLE = 4'b0001,
    LB_FERT = 4'b0010,
    LB_FEAN = 4'b0100,
    LB_NEAN = 4'b1000
  } ogl_lb_st_t;
  ogl_lb_st_t lb_r;
  ogl_lb_st_t lb_nxt;

  always_comb begin
    lb_nxt = lb_r;
    unique case (lb_r)
      LB_IDLE: begin
        if (bist_req && bist_kind == BIST_RETIMED) begin
          lb_nxt = LB_FERT;
        end else if (HAS_FE_ANA && bist_req && bist_kind == BIST_ANALOG) begin
          lb_nxt = LB_FEAN;
        end else if (HAS_NE_ANA && ne_lb_req && far_quiet) begin
          lb_nxt = LB_NEAN;
        end
      end
      LB_FERT: if (init_seq_seen) lb_nxt = LB_IDLE;
      LB_FEAN: if (init_seq_seen) lb_nxt = LB_IDLE;
      LB_NEAN: if (!ne_lb_req || !far_quiet) lb_nxt = LB_IDLE;
      default: lb_nxt = LB_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lb_r <= LB_IDLE;
    end else begin
      lb_r <= lb_nxt;
    end
  end

  assign fe_retimed_on = (lb_r == LB_FERT);
  assign fe_analog_on  = (lb_r == LB_FEAN);
  assign ne_analog_on  = (lb_r == LB_NEAN);

  a_fe_hold: assert property (@(posedge mclk) disable iff (!reset_n)
    (fe_retimed_on || fe_analog_on) && !init_seq_seen |=> $stable(lb_r))
    else $error("far-end loopback left without reset sequence");
  a_fe_entry: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(fe_retimed_on) || $rose(fe_analog_on) |-> $past(bist_req))
    else $error("far-end loopback entered without request");
  a_ne_quiet: assert property (@(posedge mclk) disable iff (!reset_n)
    ne_analog_on |-> $past(far_quiet))
    else $error("near-end loopback while far end transmits");

  // retiming fifo: received aligns are dropped, the rest kept verbatim
  logic       fifo_in_vld;
  logic       fifo_in_rdy;
  logic       fifo_out_vld;
  logic       fifo_pop;
  ogl_dword_t fifo_out;
  logic       rx_is_align;

  assign rx_is_align = (rx_word.k == K_PRIM) && (rx_word.data == PRIM_ALIGN);
  assign fifo_in_vld = rx_valid && fe_retimed_on && !rx_is_align;
  assign rx_ready    = fifo_in_rdy || !fe_retimed_on || rx_is_align;

  ogl_fifo #(.W($bits(ogl_dword_t)), .DEPTH(DEPTH)) u_fifo (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .in_valid  (fifo_in_vld),
    .in_ready  (fifo_in_rdy),
    .in_data   (rx_word),
    .out_valid (fifo_out_vld),
    .out_ready (fifo_pop),
    .out_data  (fifo_out)
  );

  // framed generator states
  typedef enum logic [5:0] {
    G_IDLE = 6'b000001,
    G_SOF  = 6'b000010,
    G_HDR  = 6'b000100,
    G_PAY  = 6'b001000,
    G_CRC  = 6'b010000,
    G_EOF  = 6'b100000
  } ogl_gen_st_t;
  ogl_gen_st_t gen_r;
  ogl_gen_st_t gen_nxt;
  logic [15:0] pay_cnt_r;
  logic [15:0] pay_cnt_nxt;
  logic [15:0] scr_r;
  logic [15:0] scr_nxt;
  logic [31:0] crc_r;
  logic [31:0] crc_nxt;
  logic [AC_W-1:0] al_cnt_r;
  logic [AC_W-1:0] al_cnt_nxt;
  logic [1:0]  al_pend_r;
  logic [1:0]  al_pend_nxt;
  logic        tx_valid_r;
  ogl_dword_t  tx_word_r;
  ogl_dword_t  tx_word_nxt;
  logic        byp_r;
  logic        byp_nxt;
  logic [47:0] scr_out;

  // output slot choice: align pair, loopback, generator, idle fill
  always_comb begin
    scr_out     = scr_step(scr_r);
    gen_nxt     = gen_r;
    pay_cnt_nxt = pay_cnt_r;
    scr_nxt     = scr_r;
    crc_nxt     = crc_r;
    al_cnt_nxt  = al_cnt_r;
    al_pend_nxt = al_pend_r;
    tx_word_nxt = tx_word_r;
    byp_nxt     = byp_r;
    fifo_pop    = 1'b0;
    // a started frame always runs on to its end marker
    if (gen_mode != GEN_FRAMED && gen_r != G_SOF && gen_r != G_HDR &&
        gen_r != G_PAY && gen_r != G_CRC && gen_r != G_EOF) begin
      gen_nxt = G_IDLE;
    end
    if (tx_ready) begin
      byp_nxt = 1'b0;
      if (al_pend_r != 2'h0) begin
        tx_word_nxt = '{data: PRIM_ALIGN, k: K_PRIM};
        al_pend_nxt = al_pend_r - 2'h1;
      end else begin
        if (al_cnt_r == AC_W'(ALIGN_EVERY - 1)) begin
          al_cnt_nxt  = '0;
          al_pend_nxt = 2'h2; // next two slots carry the align pair
        end else begin
          al_cnt_nxt = al_cnt_r + 1'b1;
        end
        if (fe_retimed_on) begin
          // dword passed unchanged, fill when fifo runs dry
          byp_nxt = 1'b1;
          if (fifo_out_vld) begin
            tx_word_nxt = fifo_out;
            fifo_pop    = 1'b1;
          end else begin
            tx_word_nxt = '{data: PRIM_ALIGN, k: K_PRIM};
          end
        end else if (gen_mode == GEN_RAW && gen_r == G_IDLE) begin
          tx_word_nxt = '{data: gen_pattern, k: K_DATA};
          byp_nxt     = 1'b1;
        end else begin
          tx_word_nxt = '{data: PRIM_SYNC, k: K_PRIM};
          unique case (gen_r)
            G_IDLE: begin
              if (gen_mode == GEN_FRAMED) gen_nxt = G_SOF;
            end
            G_SOF: begin
              tx_word_nxt = '{data: PRIM_SOF, k: K_PRIM};
              scr_nxt     = SCR_SEED;
              crc_nxt     = CRC_SEED;
              pay_cnt_nxt = '0;
              gen_nxt     = G_HDR;
            end
            G_HDR: begin
              tx_word_nxt = '{data: HDR_DATA, k: K_DATA};
              scr_nxt     = scr_out[47:32];
              crc_nxt     = crc_step(crc_r, HDR_DATA);
              gen_nxt     = G_PAY;
            end
            G_PAY: begin
              // scrambler undoes this so the pattern shows on the wire
              tx_word_nxt = '{data: gen_pattern ^ scr_out[31:0], k: K_DATA};
              scr_nxt     = scr_out[47:32];
              crc_nxt     = crc_step(crc_r, gen_pattern ^ scr_out[31:0]);
              pay_cnt_nxt = pay_cnt_r + 16'h0001;
              if (pay_cnt_r == 16'(PAY_DW - 1)) begin
                gen_nxt = G_CRC;
              end
            end
            G_CRC: begin
              tx_word_nxt = '{data: crc_r, k: K_DATA};
              scr_nxt     = scr_out[47:32];
              gen_nxt     = G_EOF;
            end
            G_EOF: begin
              tx_word_nxt = '{data: PRIM_EOF, k: K_PRIM};
              gen_nxt     = G_IDLE;
            end
            default: gen_nxt = G_IDLE;
          endcase
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      gen_r      <= G_IDLE;
      pay_cnt_r  <= '0;
      scr_r      <= SCR_SEED;
      crc_r      <= CRC_SEED;
      al_cnt_r   <= '0;
      al_pend_r  <= '0;
      tx_word_r  <= '{data: PRIM_SYNC, k: K_PRIM};
      tx_valid_r <= 1'b0;
      byp_r      <= 1'b0;
    end else begin
      gen_r      <= gen_nxt;
      pay_cnt_r  <= pay_cnt_nxt;
      scr_r      <= scr_nxt;
      crc_r      <= crc_nxt;
      al_cnt_r   <= al_cnt_nxt;
      al_pend_r  <= al_pend_nxt;
      tx_word_r  <= tx_word_nxt;
      tx_valid_r <= 1'b1;
      byp_r      <= byp_nxt;
    end
  end

  assign tx_valid      = tx_valid_r;
  assign tx_word       = tx_word_r;
  assign tx_bypass_scr = byp_r;

  a_align_pair: assert property (@(posedge mclk) disable iff (!reset_n)
    tx_ready && al_pend_r == 2'h2 |=> tx_word.data == PRIM_ALIGN)
    else $error("align pair not sent");
  a_frame_head: assert property (@(posedge mclk) disable iff (!reset_n)
    tx_ready && gen_r == G_HDR && al_pend_r == 2'h0 && !fe_retimed_on &&
    gen_mode != GEN_RAW |=> tx_word.data[7:0] == FIS_TYPE_DATA)
    else $error("header does not mark a data frame");
  a_loop_data: assert property (@(posedge mclk) disable iff (!reset_n)
    fifo_pop |=> tx_word == $past(fifo_out))
    else $error("looped dword altered");
endmodule
`default_nettype wire

//--- rtl/ogl_pkg.sv
// constants and carrier types for the gap detect and loopback block
`default_nettype none
package ogl_pkg;
  // link dword with per-byte control flags
  typedef struct packed {
    logic [31:0] data;
    logic [3:0]  k;
  } ogl_dword_t;

  // limits of one gap class, counted in out-of-band unit intervals
  typedef struct packed {
    logic [15:0] may_lo;
    logic [15:0] shall_lo;
    logic [15:0] shall_hi;
    logic [15:0] may_hi;
  } ogl_gap_lim_t;

  // link primitives and control flag patterns
  localparam logic [31:0] PRIM_ALIGN = 32'h7b4a4abc;
  localparam logic [31:0] PRIM_SYNC  = 32'hb5b5957c;
  localparam logic [31:0] PRIM_SOF   = 32'h3737b57c;
  localparam logic [31:0] PRIM_EOF   = 32'hd5d5b57c;
  localparam logic [3:0]  K_PRIM     = 4'h1;
  localparam logic [3:0]  K_DATA     = 4'h0;

  // data frame header: type code in the low byte
  localparam logic [7:0]  FIS_TYPE_DATA = 8'h46;
  localparam logic [31:0] HDR_DATA      = {24'h000000, FIS_TYPE_DATA};

  // frame check and scrambler constants
  localparam logic [31:0] CRC_POLY = 32'h04c11db7;
  localparam logic [31:0] CRC_SEED = 32'h52325032;
  localparam logic [15:0] SCR_SEED = 16'hffff;
  localparam logic [15:0] SCR_TAPS = 16'ha011;

  // defaults for sizes and periods
  localparam int FRAME_PAY_DW = 2048; // longest payload in dwords
  localparam int ALIGN_PERIOD = 256;  // dwords between align pairs
  localparam int INIT_GAPS    = 3;    // valid gaps forming a reset sequence
  localparam int FIFO_DEPTH   = 8;

  // test pattern generator modes
  typedef enum logic [1:0] {
    GEN_OFF     = 2'h0,
    GEN_RAW     = 2'h1,
    GEN_FRAMED  = 2'h2
  } ogl_gen_mode_t;

  // loopback kind requested by a self-test activate frame
  typedef enum logic [1:0] {
    BIST_NONE     = 2'h0,
    BIST_RETIMED  = 2'h1,
    BIST_ANALOG   = 2'h2
  } ogl_bist_t;
endpackage
`default_nettype wire

//--- tb/ogl_link_model.sv
// far-side link controller model: feeds dwords and takes transmit dwords
`default_nettype none
module ogl_link_model
  import ogl_pkg::*;
(
  // clock
  input  wire logic       mclk,
  // bench control
  input  wire logic       send,
  input  wire logic       stall,
  input  wire logic       pace,
  // toward the receive side of the block
  output logic            rx_valid,
  input  wire logic       rx_ready,
  output ogl_dword_t      rx_word,
  // from the transmit side of the block
  output logic            tx_ready,
  input  wire logic       tx_valid,
  input  wire ogl_dword_t tx_word
);
  timeunit 1ns;
  timeprecision 1ps;
  ogl_dword_t  sent[$];      // data dwords taken by the block
  ogl_dword_t  got[$];       // every dword the block transmitted
  logic [31:0] cnt  = 32'h00000100;
  logic        took = 1'b0;
  logic        tog  = 1'b0;
  initial begin
    rx_valid = 1'b0;
    rx_word  = '0;
    tx_ready = 1'b0;
  end
  // record transfers at the sampling edge
  always @(posedge mclk) begin
    took <= rx_valid && rx_ready;
    if (rx_valid && rx_ready && rx_word.k === K_DATA)
      sent.push_back(rx_word);
    if (tx_valid && tx_ready)
      got.push_back(tx_word);
  end
  // a request is held until taken; a released line toggles every cycle
  always @(negedge mclk) begin
    tog <= !tog;
    tx_ready <= !stall && (!pace || tog); // prompt or slow answer
    if (!rx_valid || took) begin
      if (send) begin
        rx_valid <= 1'b1;
        // stream with its own aligns, which must not come back
        rx_word <= (cnt[2:0] == 3'h5) ? {PRIM_ALIGN, K_PRIM}
                                      : {cnt, K_DATA};
        cnt <= cnt + 32'h00000001;
      end else begin
        rx_valid <= 1'b0;
        rx_word  <= ~rx_word;
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/tb.sv
// self-checking bench for the gap detect and loopback block
`default_nettype none
module tb
  import ogl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic          mclk = 1'b0, reset_n = 1'b0, act = 1'b1, tick = 1'b0;
  logic          may = 1'b0, breq = 1'b0, nereq = 1'b0, fq = 1'b0;
  logic          send = 1'b0, stall = 1'b0, pace = 1'b0, seqf;
  logic          wok, wbad, iok, ibad, iseq, fer, fea, nea;
  logic          rxv, rxr, txv, byp, txr;
  logic [3:0]    pl;
  logic [31:0]   pat = 32'h4a4a4a4a;
  ogl_bist_t     kind = BIST_RETIMED;
  ogl_gen_mode_t gm = GEN_OFF;
  ogl_dword_t    rxw, txw;
  ogl_dword_t    f[$];
  ogl_gap_lim_t  wl = {16'h000a, 16'h000c, 16'h0010, 16'h0012};
  ogl_gap_lim_t  il = {16'h001e, 16'h0020, 16'h0028, 16'h002a};
  int            n_errors = 0, samples_checked = 0;
  // block with shortened frame and align period
  ogl_gap_loop #(.PAY_DW(4), .ALIGN_EVERY(16), .DEPTH(FIFO_DEPTH),
    .HAS_FE_ANA(1'b1), .HAS_NE_ANA(1'b1)) DUT (
    .mclk(mclk), .reset_n(reset_n), .oob_activity(act),
    .oob_ui_tick(tick), .wake_lim(wl), .init_lim(il), .accept_may(may),
    .wake_gap_ok(wok), .wake_gap_bad(wbad), .init_gap_ok(iok),
    .init_gap_bad(ibad), .init_seq_seen(iseq), .bist_req(breq),
    .bist_kind(kind), .ne_lb_req(nereq), .far_quiet(fq),
    .fe_retimed_on(fer), .fe_analog_on(fea), .ne_analog_on(nea),
    .rx_valid(rxv), .rx_ready(rxr), .rx_word(rxw), .gen_mode(gm),
    .gen_pattern(pat), .tx_ready(txr), .tx_valid(txv), .tx_word(txw),
    .tx_bypass_scr(byp));
  // far side of the link
  ogl_link_model m (.mclk(mclk), .send(send), .stall(stall), .pace(pace),
    .rx_valid(rxv), .rx_ready(rxr), .rx_word(rxw), .tx_ready(txr),
    .tx_valid(txv), .tx_word(txw));
  always #2.5 mclk = ~mclk;
  task automatic summarize();
    $display("errors %0d of %0d checks", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [35:0] s, input logic [35:0] e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // one quiet gap of n unit intervals, then a burst; gather class pulses
  task automatic gap(input int n);
    act = 1'b0;
    cyc(6);
    repeat (n) begin
      tick = 1'b1;
      cyc(1);
      tick = 1'b0;
      cyc(1);
    end
    act = 1'b1;
    pl = 4'h0;
    repeat (12) begin
      cyc(1);
      pl = pl | {wok, wbad, iok, ibad};
      seqf = seqf | iseq;
    end
  endtask
  task automatic enter(input ogl_bist_t k);
    kind = k;
    breq = 1'b1;
    cyc(1);
    breq = 1'b0;
    cyc(2);
  endtask
  // three init gaps close any far-end loopback
  task automatic leave();
    seqf = 1'b0;
    repeat (3) gap(36);
    chk(36'(seqf), 36'h1);
    cyc(2);
    chk(36'({fer, fea}), 36'h0);
  endtask
  // received stream without aligns and idle fill
  task automatic filt();
    f = {};
    foreach (m.got[i])
      if (m.got[i].data !== PRIM_ALIGN && m.got[i].data !== PRIM_SYNC)
        f.push_back(m.got[i]);
  endtask
  // aligns on the wire come in runs of two or more, never alone
  task automatic pairs();
    int np;
    int nb;
    np = 0;
    nb = 0;
    for (int i = 1; i + 1 < m.got.size(); i++)
      if (m.got[i].data === PRIM_ALIGN && m.got[i-1].data !== PRIM_ALIGN)
      begin
        np++;
        if (m.got[i+1].data !== PRIM_ALIGN) nb++;
      end
    chk(36'(nb), 36'h0);
    chk(36'(np > 0), 36'h1);
  endtask
  // link scrambler stand-in: syndrome dword k after the seed
  function automatic logic [31:0] syn(input int k);
    logic [15:0] st;
    logic [31:0] w;
    st = SCR_SEED;
    w  = '0;
    for (int j = 0; j <= k; j++)
      for (int i = 0; i < 32; i++) begin
        w[i] = st[15];
        st   = {st[14:0], 1'b0} ^ (st[15] ? SCR_TAPS : 16'h0000);
      end
    return w;
  endfunction
  // table of gap lengths against both classes, optional range on and off
  task automatic t_gaps();
    int          gn[7] = '{14, 11, 11, 5, 36, 31, 31};
    logic        gy[7] = '{0, 0, 1, 0, 0, 1, 0};
    logic [3:0]  ge[7] = '{4'h9, 4'h5, 4'h9, 4'h5, 4'h6, 4'h6, 4'h5};
    for (int i = 0; i < 7; i++) begin
      may = gy[i];
      gap(gn[i]);
      chk(36'(pl), 36'(ge[i]));
    end
    may = 1'b0;
  endtask
  task automatic t_retimed();
    enter(BIST_RETIMED);
    chk(36'({fer, fea, nea}), 36'h4);
    enter(BIST_ANALOG);
    chk(36'({fer, fea, nea}), 36'h4);
    m.sent.delete();
    m.got.delete();
    stall = 1'b1;
    send = 1'b1;
    for (int i = 0; i < 40 && rxr === 1'b1; i++) cyc(1);
    chk(36'(rxr), 36'h0);
    stall = 1'b0;
    pace = 1'b1;
    cyc(150);
    for (int i = 0; i < 6 && txw.k !== K_DATA; i++) cyc(1);
    chk(36'({txv, byp}), 36'h3);
    pace = 1'b0;
    send = 1'b0;
    cyc(60);
    filt();
    chk(36'(f.size()), 36'(m.sent.size()));
    foreach (f[i]) chk(f[i], m.sent[i]);
    pairs();
    gap(14);
    chk(36'(fer), 36'h1);
    leave();
  endtask
  task automatic t_analog();
    enter(BIST_ANALOG);
    chk(36'({fer, fea, nea}), 36'h2);
    gap(5);
    chk(36'(fea), 36'h1);
    leave();
  endtask
  task automatic t_near();
    nereq = 1'b1;
    cyc(3);
    chk(36'(nea), 36'h0);
    fq = 1'b1;
    cyc(3);
    chk(36'(nea), 36'h1);
    fq = 1'b0;
    cyc(3);
    chk(36'(nea), 36'h0);
    nereq = 1'b0;
  endtask
  task automatic t_gen();
    int s;
    m.got.delete();
    gm = GEN_FRAMED;
    pace = 1'b1;
    cyc(120);
    chk(36'({txv, byp}), 36'h2);
    gm = GEN_OFF;
    pace = 1'b0;
    cyc(20);
    filt();
    s = 0;
    while (s < f.size() && f[s].data !== PRIM_SOF) s++;
    chk(f[s+1], {HDR_DATA, K_DATA});
    chk(36'(f[s+2].data !== pat), 36'h1);
    for (int i = 0; i < 4; i++)
      chk(36'(f[s+2+i].data ^ syn(i + 1)), 36'(pat));
    chk(f[s+7], {PRIM_EOF, K_PRIM});
    chk(f[s+8], {PRIM_SOF, K_PRIM});
    pairs();
    m.got.delete();
    gm = GEN_RAW;
    cyc(40);
    for (int i = 0; i < 4 && txw.data !== pat; i++) cyc(1);
    chk(36'({txv, byp}), 36'h3);
    gm = GEN_OFF;
    cyc(10);
    filt();
    chk(f[5], {pat, K_DATA});
    chk(f[20], {pat, K_DATA});
  endtask
  // a hang ends in the closing report
  initial begin
    #400000;
    n_errors++;
    summarize();
  end
  initial begin
    cyc(3);
    reset_n = 1'b1;
    cyc(4);
    t_gaps();
    t_retimed();
    t_analog();
    t_near();
    t_gen();
    summarize();
  end
endmodule
`default_nettype wire
